// >>> design/ibd_top.sv
// AHB-Lite slave with baud reload low byte, diagnostic state and a small protocol engine.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "ibd_defines.svh"
module ibd_top
  import ibd_pkg::*;
#(
  parameter logic [7:0] RELOAD_HI = `IBD_RELOAD_HI_RST
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // Bus side state.
  ibd_aphase_t ap_r, ap_nxt;
  logic [7:0]  reload_lo_r, reload_lo_nxt;
  logic        sel_r, sel_nxt;
  ibd_ctrl_t   ctrl_r, ctrl_nxt;
  logic        pend_r, pend_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;

  // Line and engine state.
  logic        scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic [4:0]  code_r, code_nxt;
  logic        phase_r, phase_nxt;
  logic        nack_r, nack_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic        scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;

  logic        ap_take, rd_take, wr_lo, wr_sel, wr_ctrl, tick, adv, stop_flag;
  logic        sending, tx_bit, is_bit;
  logic [2:0]  bit_idx;
  logic [7:0]  lo_eff;
  logic        sel_eff;
  ibd_ctrl_t   ctrl_eff;
  logic [7:0]  readback_select_a_byte;

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_oe_r;
  assign sda_oe    = sda_oe_r;

  // Pins are asynchronous to hclk; the first stage feeds only the second.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  assign ap_take = hsel & htrans[1] & hready & (haddr[31:14] == 18'h0);
  assign rd_take = hsel & htrans[1] & hready & ~hwrite;
  assign wr_lo   = ap_r.valid & ap_r.write & (ap_r.idx == `IBD_IDX_RELOAD_LO);
  assign wr_sel  = ap_r.valid & ap_r.write & (ap_r.idx == `IBD_IDX_SEL);
  assign wr_ctrl = ap_r.valid & ap_r.write & (ap_r.idx == `IBD_IDX_CTRL);

  // A read right behind a write sees the written value, since the read data
  // is fetched in the same edge the write lands.
  assign lo_eff    = wr_lo ? hwdata[7:0] : reload_lo_r;
  assign sel_eff   = wr_sel ? hwdata[0] : sel_r;
  assign ctrl_eff  = wr_ctrl ? ibd_ctrl_t'(hwdata[19:0]) : ctrl_r;
  assign stop_flag = (code_r == `IBD_S_STOP1) | (code_r == `IBD_S_STOP2);
  assign readback_select_a_byte = {scl_s_r, sda_s_r, stop_flag, code_r};

  always_comb begin
    ap_nxt        = '0;
    ap_nxt.valid  = ap_take;
    ap_nxt.write  = hwrite;
    ap_nxt.idx    = haddr[13:2];
    reload_lo_nxt = lo_eff;
    sel_nxt       = sel_eff;
    ctrl_nxt      = ctrl_eff;
    // Hardware clears the pending start; a new request wins over the clear.
    pend_nxt      = pend_r & ~(code_r == `IBD_S_IDLE && tick);
    if (wr_ctrl && hwdata[`IBD_F_GO]) begin
      pend_nxt = 1'b1;
    end
    hrdata_nxt = hrdata_r;
    // A read outside the window still answers, with zero, so stale data never leaks.
    if (rd_take) begin
      hrdata_nxt = 32'h0;
    end
    if (ap_take && !hwrite) begin
      case (haddr[13:2])
        `IBD_IDX_RELOAD_LO: hrdata_nxt[7:0] = sel_eff ? cnt_r[7:0] : lo_eff;
        `IBD_IDX_READBACK_SELECT_A_ST:   hrdata_nxt[7:0] = readback_select_a_byte;
        `IBD_IDX_SEL:       hrdata_nxt[0]   = sel_eff;
        `IBD_IDX_CTRL: begin
          hrdata_nxt[19:0]        = ctrl_eff;
          hrdata_nxt[`IBD_F_BUSY] = pend_r | (code_r != `IBD_S_IDLE);
          hrdata_nxt[`IBD_F_NACK] = nack_r;
          hrdata_nxt[31:24]       = rx_r;
        end
        default:            hrdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r        <= '0;
      reload_lo_r <= `IBD_RELOAD_LO_RST;
      sel_r       <= 1'b0;
      ctrl_r      <= '0;
      pend_r      <= 1'b0;
      hrdata_r    <= 32'h0;
    end else begin
      ap_r        <= ap_nxt;
      reload_lo_r <= reload_lo_nxt;
      sel_r       <= sel_nxt;
      ctrl_r      <= ctrl_nxt;
      pend_r      <= pend_nxt;
      hrdata_r    <= hrdata_nxt;
    end
  end

  // Down counter reloads at one, so each phase lasts reload-value cycles.
  assign tick = (cnt_r <= `IBD_CNT_ONE);
  assign adv  = tick & phase_r;

  // Bit position inside the byte being moved, from the state code.
  always_comb begin
    is_bit  = 1'b1;
    bit_idx = 3'h0;
    tx_bit  = 1'b1;
    sending = 1'b1;
    if (code_r >= `IBD_S_DATA7 && code_r <= `IBD_S_DATA0) begin
      bit_idx = 3'(`IBD_S_DATA0 - code_r);
      tx_bit  = ctrl_r.data[bit_idx];
      sending = ~ctrl_r.rw;
    end else if (code_r >= `IBD_S_T1MSB && code_r <= `IBD_S_T1LSB) begin
      bit_idx = 3'(`IBD_S_T1LSB - code_r);
      tx_bit  = 1'({`IBD_TEN_PREFIX, ctrl_r.addr[9:8], ctrl_r.rw} >> bit_idx);
    end else if (code_r >= `IBD_S_AMSB) begin
      bit_idx = 3'(5'h0 - code_r);
      tx_bit  = ctrl_r.ten ? ctrl_r.addr[bit_idx] : ctrl_r.addr[3'(bit_idx - 3'h1)];
    end else if (code_r == `IBD_S_ALSB) begin
      tx_bit  = ctrl_r.ten ? ctrl_r.addr[0] : ctrl_r.rw;
    end else begin
      is_bit  = 1'b0;
    end
  end

  always_comb begin
    cnt_nxt   = tick ? {RELOAD_HI, reload_lo_r} : cnt_r - 16'h1;
    code_nxt  = code_r;
    phase_nxt = (code_r == `IBD_S_IDLE) ? 1'b0 : phase_r ^ tick;
    nack_nxt  = nack_r;
    rx_nxt    = rx_r;
    if (code_r == `IBD_S_IDLE) begin
      if (tick && pend_r) begin
        code_nxt = `IBD_S_START;
        nack_nxt = 1'b0;
      end
    end else if (adv) begin
      if (code_r >= `IBD_S_DATA7 && code_r <= `IBD_S_DATA0 && ctrl_r.rw) begin
        rx_nxt = {rx_r[6:0], sda_s_r};
      end
      case (code_r)
        `IBD_S_START: code_nxt = ctrl_r.ten ? `IBD_S_T1MSB : `IBD_S_AMSB;
        `IBD_S_T1LSB: code_nxt = `IBD_S_T1ACK;
        `IBD_S_T1ACK: code_nxt = sda_s_r ? `IBD_S_STOP1 : `IBD_S_AMSB;
        `IBD_S_ABIT1: code_nxt = `IBD_S_ALSB;
        `IBD_S_ALSB:  code_nxt = `IBD_S_AACK;
        `IBD_S_AACK:  code_nxt = sda_s_r ? `IBD_S_STOP1 : `IBD_S_DATA7;
        `IBD_S_DATA0: code_nxt = `IBD_S_DACK;
        `IBD_S_DACK:  code_nxt = sda_s_r ? `IBD_S_DNACK : `IBD_S_STOP1;
        `IBD_S_DNACK: code_nxt = `IBD_S_STOP1;
        `IBD_S_STOP1: code_nxt = `IBD_S_STOP2;
        `IBD_S_STOP2: code_nxt = `IBD_S_IDLE;
        default:      code_nxt = code_r + 5'h1;
      endcase
      if ((code_r == `IBD_S_T1ACK || code_r == `IBD_S_AACK) && sda_s_r) begin
        nack_nxt = 1'b1;
      end
      if (code_r == `IBD_S_DACK && sda_s_r && !ctrl_r.rw) begin
        nack_nxt = 1'b1;
      end
    end
  end

  // Pin drive follows the present code and phase; a read byte ends with the
  // master leaving the line released, which the slave sees as not-acknowledge.
  always_comb begin
    scl_oe_nxt = 1'b0;
    sda_oe_nxt = 1'b0;
    case (code_nxt)
      `IBD_S_IDLE:  sda_oe_nxt = 1'b0;
      `IBD_S_START: sda_oe_nxt = 1'b1;
      `IBD_S_STOP1: begin
        scl_oe_nxt = 1'b1;
        sda_oe_nxt = 1'b1;
      end
      `IBD_S_STOP2: sda_oe_nxt = ~phase_nxt;
      default: begin
        scl_oe_nxt = ~phase_nxt;
        sda_oe_nxt = 1'b0;
      end
    endcase
    if (is_bit && sending && code_nxt == code_r && code_r != `IBD_S_IDLE) begin
      sda_oe_nxt = ~tx_bit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r    <= {`IBD_RELOAD_HI_RST, `IBD_RELOAD_LO_RST};
      code_r   <= `IBD_S_IDLE;
      phase_r  <= 1'b0;
      nack_r   <= 1'b0;
      rx_r     <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      code_r   <= code_nxt;
      phase_r  <= phase_nxt;
      nack_r   <= nack_nxt;
      rx_r     <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

endmodule

// >>> inc/ibd_defines.svh
// Register indices, field positions, reset values and state codes of the baud/readback_select_a block.
// Contract
// - Reload low byte at F54h, resets FFh
// - Readback select high returns live counter low
// - Read-only diagnostic state at F55h
// - Bit 7 shows sampled clock line
// - Bit 6 shows sampled data line
// - Bit 5 shows internal stop count flag
// - Codes 02h..09h are data bits 7..0
// - 0Ah data acknowledge, 0Bh not-acknowledge half
// - Stop uses codes 0Ch then 0Dh
// - 0Eh is address acknowledge state
// - 0Fh is final address byte bit 0
// - Ten-bit first byte uses 10h..17h
// - 18h is first address byte acknowledge
// - 19h..1Fh are address bits 7..1
// - Select low returns stored reload value
`ifndef IBD_DEFINES_SVH
`define IBD_DEFINES_SVH
`define IBD_IDX_RELOAD_LO 12'hf54
`define IBD_IDX_READBACK_SELECT_A_ST   12'hf55
`define IBD_IDX_SEL       12'hf56
`define IBD_IDX_CTRL      12'hf57
`define IBD_RELOAD_LO_RST 8'hff
`define IBD_RELOAD_HI_RST 8'hff
`define IBD_CNT_ONE       16'h0001
`define IBD_C_DATA_LO     5'h08
`define IBD_C_DATA_HI     5'h09
`define IBD_F_GO          20
`define IBD_F_TEN         19
`define IBD_F_RW          18
`define IBD_F_BUSY        21
`define IBD_F_NACK        22
`define IBD_S_IDLE        5'h00
`define IBD_S_START       5'h01
`define IBD_S_DATA7       5'h02
`define IBD_S_DATA0       5'h09
`define IBD_S_DACK        5'h0a
`define IBD_S_DNACK       5'h0b
`define IBD_S_STOP1       5'h0c
`define IBD_S_STOP2       5'h0d
`define IBD_S_AACK        5'h0e
`define IBD_S_ALSB        5'h0f
`define IBD_S_T1MSB       5'h10
`define IBD_S_T1LSB       5'h17
`define IBD_S_T1ACK       5'h18
`define IBD_S_AMSB        5'h19
`define IBD_S_ABIT1       5'h1f
`define IBD_TEN_PREFIX    5'h1e
`endif

// >>> inc/ibd_pkg.sv
// Types shared by the baud/readback_select_a block.
package ibd_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] idx;
  } ibd_aphase_t;
  typedef struct packed {
    logic       ten;
    logic       rw;
    logic [9:0] addr;
    logic [7:0] data;
  } ibd_ctrl_t;
endpackage

// >>> tb/ibd_assertions.sv
// Port-level checks on the baud reload low byte and diagnostic state block.
`timescale 1ns/1ps
module ibd_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        sda_i,
  input wire logic        sda_o
);
  logic        rd_q;
  logic [11:0] ix_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Addresses above the window fold onto an index that nothing decodes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      ix_q <= 12'h0;
    end else begin
      rd_q <= hsel && htrans[1] && hreadyout && !hwrite;
      ix_q <= (haddr[31:14] != 18'h0) ? 12'hfff : haddr[13:2];
    end
  end
  wire logic st_rd = rd_q && ix_q == 12'hf55;
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_pins_drain: assert property (!scl_o && !sda_o) else $error("pin driven high");
  chk_read_hold: assert property (!rd_q |-> $stable(hrdata)) else $error("hrdata moved");
  chk_unmapped_zero: assert property (rd_q && !(ix_q inside {[12'hf54:12'hf57]}) |->
    hrdata == 32'h0) else $error("unmapped read not zero");
  chk_upper_zero: assert property (
    rd_q && ix_q inside {12'hf54, 12'hf55} |-> hrdata[31:8] == 24'h0) else $error("upper bits");
  chk_clock_view: assert property (
    st_rd |-> hrdata[7] == $past(scl_i, 3) || hrdata[7] == $past(scl_i, 4)) else $error("clock bit");
  chk_data_view: assert property (
    st_rd |-> hrdata[6] == $past(sda_i, 3) || hrdata[6] == $past(sda_i, 4)) else $error("data bit");
  chk_stop_flag: assert property (
    st_rd |-> hrdata[5] == (hrdata[4:0] inside {5'h0c, 5'h0d})) else $error("stop flag");
  cover property (st_rd && hrdata[5]);
  cover property (st_rd && hrdata[4:0] == 5'h18);
  cover property (st_rd && hrdata[4:0] == 5'h0a);
  cover property (st_rd && hrdata[4:0] == 5'h0b);
endmodule

// >>> tb/ibd_slave.sv
// Behavioural two-wire target: acknowledges address bytes, then takes or sends one data byte.
`timescale 1ns/1ps
module ibd_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_on,
  input  wire logic       rd_on,
  input  wire logic [1:0] n_adr,
  input  wire logic [7:0] rd_byte,
  output logic            pull
);
  int cnt = 0;
  int nb = 0;
  // A falling data line while the clock line is high marks a start.
  always @(negedge sda) begin
    if (scl) begin
      cnt = 0;
      nb = 0;
    end
  end
  always @(negedge scl) begin
    if (cnt == 9) begin
      nb = nb + 1;
    end
    cnt = (cnt == 9) ? 1 : cnt + 1;
  end
  // Acknowledge runs from the ninth falling clock to the tenth; a sending target
  // drives only the first data byte and then leaves the line to the master.
  wire logic adr_b = nb < n_adr;
  wire logic dat_b = nb == n_adr;
  assign pull = ((adr_b || (dat_b && !rd_on)) && ack_on && cnt == 9) ||
                (dat_b && rd_on && cnt >= 1 && cnt <= 8 && !rd_byte[8 - cnt]);
endmodule

// >>> tb/tb_i2c_baud_low_and_readback_select_a_state.sv
// Self-checking bench of the baud reload low byte and diagnostic state block.
`timescale 1ns/1ps
`include "ibd_defines.svh"
`define TB_CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_i2c_baud_low_and_readback_select_a_state;
  localparam logic [31:0] A_LO = {18'h0, `IBD_IDX_RELOAD_LO, 2'b00};
  localparam logic [31:0] A_ST = {18'h0, `IBD_IDX_READBACK_SELECT_A_ST, 2'b00};
  localparam logic [31:0] A_SEL = {18'h0, `IBD_IDX_SEL, 2'b00};
  localparam logic [31:0] A_CTL = {18'h0, `IBD_IDX_CTRL, 2'b00};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v1, v;
  logic        ext_scl = 1'b0, ext_sda = 1'b0, ack_on = 1'b1, rd_on = 1'b0;
  logic [1:0]  n_adr = 2'h1;
  logic [7:0]  rd_byte = 8'h00;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, pull;
  logic [4:0]  exp_q[$], got_q[$];
  int          err_total = 0, n_tests = 0;
  wire logic   scl_w = ~(scl_oe | ext_scl);
  wire logic   sda_w = ~(sda_oe | pull | ext_sda);
  ibd_top #(.RELOAD_HI(8'h00)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
  ibd_slave slv_u (.scl(scl_w), .sda(sda_w), .ack_on(ack_on), .rd_on(rd_on), .n_adr(n_adr),
    .rd_byte(rd_byte), .pull(pull));
  initial forever #5 hclk = ~hclk;
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask
  // Polls the state field every two cycles; each state lasts eight, so none is missed.
  task automatic run(input bit ten, input bit ack, input bit rw, input logic [9:0] ad,
                     input logic [7:0] d);
    logic [4:0] last;
    int n;
    exp_q = '{5'h01};
    if (ten) for (int k = 16; k <= 24; k++) exp_q.push_back(k[4:0]);
    for (int k = 25; k <= 31; k++) exp_q.push_back(k[4:0]);
    exp_q.push_back(5'h0f);
    exp_q.push_back(5'h0e);
    if (ack) for (int k = 2; k <= 10; k++) exp_q.push_back(k[4:0]);
    if (ack && rw) exp_q.push_back(5'h0b);
    exp_q.push_back(5'h0c);
    exp_q.push_back(5'h0d);
    exp_q.push_back(5'h00);
    ack_on <= ack;
    rd_on <= rw;
    n_adr <= ten ? 2'h2 : 2'h1;
    rd_byte <= d;
    v = (32'h1 << `IBD_F_GO) | (32'(ten) << `IBD_F_TEN) | (32'(rw) << `IBD_F_RW);
    bus(1, A_CTL, v | {14'h0, ad, d}, rd);
    got_q.delete();
    last = 5'h00;
    n = 0;
    do begin
      bus(0, A_ST, 0, rd);
      if (rd[4:0] !== last) got_q.push_back(rd[4:0]);
      last = rd[4:0];
      n++;
      if (n > 40000) begin
        err_total++;
        end_sim();
      end
    end while (!(last === 5'h00 && got_q.size() > 0));
    `TB_CHK("len", exp_q.size(), got_q.size())
    for (int k = 0; k < exp_q.size(); k++) begin
      `TB_CHK("code", exp_q[k], got_q[k])
    end
    bus(0, A_CTL, 0, rd);
    `TB_CHK("nack", !ack, rd[`IBD_F_NACK])
    if (rw) `TB_CHK("rx", d, rd[31:24])
  endtask
  initial begin
    void'($urandom(32'hc7e8));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(0, A_LO, 0, rd);
    `TB_CHK("lo_rst", 32'hff, rd)
    bus(0, A_ST, 0, rd);
    `TB_CHK("st_rst", 32'hc0, rd)
    bus(1, A_ST, $urandom, rd);
    bus(0, A_ST, 0, rd);
    `TB_CHK("st_ro", 32'hc0, rd)
    bus(1, A_SEL, 1, rd);
    bus(0, A_LO, 0, v1);
    bus(0, A_LO, 0, rd);
    `TB_CHK("cnt", (v1 - 32'h2) & 32'hff, rd)
    bus(1, A_SEL, 0, rd);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 32'h0 : $urandom;
      bus(1, A_LO, v, rd);
      bus(0, A_LO, 0, rd);
      `TB_CHK("lo_rw", v & 32'hff, rd)
    end
    bus(0, A_LO | 32'h4000, 0, rd);
    `TB_CHK("unmap", 32'h0, rd)
    for (int i = 0; i < 4; i++) begin
      ext_scl <= i[0];
      ext_sda <= i[1];
      repeat (5) @(posedge hclk);
      bus(0, A_ST, 0, rd);
      `TB_CHK("lines", {~i[0], ~i[1]}, rd[7:6])
    end
    ext_scl <= 1'b0;
    ext_sda <= 1'b0;
    repeat (5) @(posedge hclk);
    bus(1, A_LO, 32'h4, rd);
    run(0, 1, 0, 10'($urandom) & 10'h07f, 8'($urandom));
    run(1, 1, 0, 10'($urandom), 8'($urandom));
    run(0, 0, 0, 10'($urandom) & 10'h07f, 8'($urandom));
    run(0, 1, 1, 10'($urandom) & 10'h07f, 8'($urandom));
    run(1, 1, 1, 10'($urandom), 8'($urandom));
    end_sim();
  end
endmodule
bind ibd_top ibd_chk chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .scl_i(scl_i), .scl_o(scl_o), .sda_i(sda_i), .sda_o(sda_o));
